// *** core/pwm_timer_pkg.sv ***
// Constants shared by the PWM timer and compare stage
package pwm_timer_pkg;
  localparam int unsigned CNT_WIDTH = 16;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE = 16'h0001;
  localparam logic DIR_DOWN = 1'b0;
  localparam logic DIR_UP = 1'b1;
  localparam logic MODE_DOWN = 1'b0;
  localparam logic MODE_UPDOWN = 1'b1;
  localparam int unsigned NUM_CMP = 2;
  localparam int unsigned CMP_A = 0;
  localparam int unsigned CMP_B = 1;
endpackage

// *** core/pwm_cmp_if.sv ***
// Interface carrying counter state to the comparator bank
`timescale 1ns/1ps
`default_nettype none
interface pwm_cmp_if #(parameter int unsigned W = 16, parameter int unsigned N = 2);
  // Counter side
  logic [W-1:0] count;
  logic [W-1:0] load;
  logic dir;
  logic run;
  // Match values in
  logic [W-1:0] match_val [N];
  // Qualified match pulses out
  logic [N-1:0] up_hit;
  logic [N-1:0] down_hit;
  modport cnt (output count, load, dir, run, match_val, input up_hit, down_hit);
  modport cmp (input count, load, dir, run, match_val, output up_hit, down_hit);
endinterface
`default_nettype wire

// *** core/pwm_cmp_bank.sv ***
// Comparator bank producing direction-qualified match flags
`timescale 1ns/1ps
`default_nettype none
module pwm_cmp_bank #(
  parameter int unsigned N = 2
) (
  // Counter link
  pwm_cmp_if.cmp bus
);
  // One comparator per match value
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cmp
      logic hit;
      // never above load
      // A match beyond load can still equal a count left above a lowered load, so it is gated
      assign hit = bus.run && (bus.count == bus.match_val[g]) &&
                   (bus.match_val[g] <= bus.load);
      assign bus.up_hit[g] = hit && (bus.dir == pwm_timer_pkg::DIR_UP);
      assign bus.down_hit[g] = hit && (bus.dir == pwm_timer_pkg::DIR_DOWN);
    end
  endgenerate
endmodule // pwm_cmp_bank
`default_nettype wire

// *** core/pwm_timer.sv ***
// PWM generator counter with zero, load and compare event pulses
// Notes on behaviour
// - One 16-bit counter, down or up/down.
// - Down mode: load down to zero, repeat.
// - Up/down mode: zero up to load, back.
// - Direction low in down mode, toggles otherwise.
// - One-cycle pulse when count is zero.
// - One-cycle pulse when count equals load.
// - Down mode: load pulse follows zero pulse.
// - Two comparators, one-cycle match pulses each.
// - Up/down matches split by direction.
// - Match above load never pulses.
// - Four events down, six in up/down.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer #(
  parameter int unsigned W = pwm_timer_pkg::CNT_WIDTH
) (
  // Clock, reset, enable
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic i_clk_en,
  // Configuration
  input wire logic i_run,
  input wire logic i_mode,
  input wire logic [W-1:0] i_load,
  input wire logic [W-1:0] i_match_a,
  input wire logic [W-1:0] i_match_b,
  // State outputs
  output logic [W-1:0] o_count,
  output logic o_dir,
  // Event pulses
  output logic o_zero,
  output logic o_load,
  output logic o_match_a_up,
  output logic o_match_a_down,
  output logic o_match_b_up,
  output logic o_match_b_down
);
  // The counter steps on every enabled edge while running.
  // Event pulses are registered, so each one trails the count value
  // that caused it by one cycle; downstream logic must allow for that.
  // Load and match values are used live: a change takes effect on the
  // next edge, and nothing here buffers them until the count wraps.
  // Counter state
  logic [W-1:0] count_q, count_d;
  logic dir_q, dir_d;
  // Registered events
  logic zero_q, zero_d;
  logic load_q, load_d;
  logic [1:0] aup_q, aup_d;
  logic [1:0] adn_q, adn_d;
  // Link to comparators
  pwm_cmp_if #(.W(W), .N(pwm_timer_pkg::NUM_CMP)) link ();

  // Comparator bank
  pwm_cmp_bank #(.N(pwm_timer_pkg::NUM_CMP)) u_cmp (
    .bus(link)
  );

  // Drive link from counter state
  assign link.count = count_q;
  assign link.load = i_load;
  assign link.dir = dir_q;
  assign link.run = i_run;
  assign link.match_val[pwm_timer_pkg::CMP_A] = i_match_a;
  assign link.match_val[pwm_timer_pkg::CMP_B] = i_match_b;

  // Next count and direction
  // Down mode ignores the stored direction and forces it low.
  // Up/down mode turns round at load and at zero; a load of zero
  // keeps the count parked at zero while the direction still flips.
  // A load lowered below the count while rising makes the counter
  // turn round at once and walk down to zero.
  always_comb begin
    count_d = count_q;
    dir_d = dir_q;
    if (i_run) begin
      if (i_mode == pwm_timer_pkg::MODE_DOWN) begin
        dir_d = pwm_timer_pkg::DIR_DOWN;
        if (count_q == pwm_timer_pkg::CNT_ZERO) begin
          count_d = i_load;
        end else begin
          count_d = count_q - pwm_timer_pkg::CNT_ONE;
        end
      end else begin
        if (dir_q == pwm_timer_pkg::DIR_UP) begin
          if (count_q >= i_load) begin
            dir_d = pwm_timer_pkg::DIR_DOWN;
            count_d = (i_load == pwm_timer_pkg::CNT_ZERO) ? count_q :
                      count_q - pwm_timer_pkg::CNT_ONE;
          end else begin
            count_d = count_q + pwm_timer_pkg::CNT_ONE;
          end
        end else begin
          // Turn round at zero
          if (count_q == pwm_timer_pkg::CNT_ZERO) begin
            dir_d = pwm_timer_pkg::DIR_UP;
            count_d = (i_load == pwm_timer_pkg::CNT_ZERO) ? count_q :
                      count_q + pwm_timer_pkg::CNT_ONE;
          end else if (count_q > i_load) begin
            // Count above a lowered load runs down
            count_d = count_q - pwm_timer_pkg::CNT_ONE;
          end else begin
            count_d = count_q - pwm_timer_pkg::CNT_ONE;
          end
        end
      end
    end
  end

  // Next event pulses
  // All pulses are gated by the run control, so a stopped counter
  // sitting at zero or load does not repeat its events.
  always_comb begin
    zero_d = i_run && (count_q == pwm_timer_pkg::CNT_ZERO);
    load_d = i_run && (count_q == i_load);
    aup_d = link.up_hit;
    adn_d = link.down_hit;
  end

  // Counter and event registers
  // The enable freezes counter and pulses alike, so a pulse that is
  // high when the enable drops stays high until the enable returns.
  // single counter
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      count_q <= pwm_timer_pkg::CNT_ZERO;
      dir_q <= pwm_timer_pkg::DIR_DOWN;
      zero_q <= 1'b0;
      load_q <= 1'b0;
      aup_q <= 2'h0;
      adn_q <= 2'h0;
    end else if (i_clk_en) begin
      count_q <= count_d;
      dir_q <= dir_d;
      zero_q <= zero_d;
      load_q <= load_d;
      aup_q <= aup_d;
      adn_q <= adn_d;
    end
  end

  // Outputs
  // event set
  assign o_count = count_q;
  assign o_dir = dir_q;
  assign o_zero = zero_q;
  assign o_load = load_q;
  assign o_match_a_up = aup_q[pwm_timer_pkg::CMP_A];
  assign o_match_b_up = aup_q[pwm_timer_pkg::CMP_B];
  assign o_match_a_down = adn_q[pwm_timer_pkg::CMP_A];
  assign o_match_b_down = adn_q[pwm_timer_pkg::CMP_B];

  // Checks
  // load follows zero
  a_zero_then_load: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (o_zero && i_mode == pwm_timer_pkg::MODE_DOWN && i_clk_en && i_run &&
     $stable(i_load)) |=> ##0 (!i_clk_en || o_load || !$stable(i_mode)))
    else $error("load pulse missed after zero");
  a_dir_low_down: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_mode == pwm_timer_pkg::MODE_DOWN && i_run && i_clk_en) |=> !o_dir)
    else $error("direction high in down mode");
  a_zero_pulse: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en) |=> (o_zero == ($past(i_run) && $past(o_count) == pwm_timer_pkg::CNT_ZERO)))
    else $error("zero pulse wrong");
  a_load_pulse: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en) |=> (o_load == ($past(i_run) && $past(o_count) == $past(i_load))))
    else $error("load pulse wrong");
  a_reload: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && i_mode == pwm_timer_pkg::MODE_DOWN &&
     o_count == pwm_timer_pkg::CNT_ZERO) |=> (o_count == $past(i_load)))
    else $error("no reload at zero");
  a_up_step: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && i_mode == pwm_timer_pkg::MODE_UPDOWN && o_dir &&
     o_count < i_load) |=> (o_count == $past(o_count) + pwm_timer_pkg::CNT_ONE))
    else $error("up step wrong");
  a_no_match_high: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_match_a > i_load) |=> !(o_match_a_up || o_match_a_down))
    else $error("match above load pulsed");
  a_match_split: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    !(o_match_a_up && o_match_a_down) && !(o_match_b_up && o_match_b_down))
    else $error("both directions matched");
  a_match_b: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && o_count == i_match_b && i_match_b <= i_load) |=>
    (o_match_b_up || o_match_b_down))
    else $error("match B pulse missed");
  // match A pulses
  // A reachable match value must always produce a pulse on A
  a_match_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && o_count == i_match_a && i_match_a <= i_load) |=>
    (o_match_a_up || o_match_a_down))
    else $error("match A pulse missed");
  // no B match above load
  // Comparator B stays silent while its value is out of range
  a_no_match_b_high: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_match_b > i_load) |=> !(o_match_b_up || o_match_b_down))
    else $error("match B above load pulsed");
  // down count steps
  // Away from zero the down counter loses exactly one per cycle
  a_down_step: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && i_mode == pwm_timer_pkg::MODE_DOWN &&
     o_count != pwm_timer_pkg::CNT_ZERO) |=>
    (o_count == $past(o_count) - pwm_timer_pkg::CNT_ONE))
    else $error("down step wrong");
  // falling half steps
  // Up/down counter falling towards zero loses one per cycle
  a_fall_step: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && i_mode == pwm_timer_pkg::MODE_UPDOWN && !o_dir &&
     o_count != pwm_timer_pkg::CNT_ZERO) |=>
    (o_count == $past(o_count) - pwm_timer_pkg::CNT_ONE))
    else $error("falling step wrong");
  // turn at top
  // Reaching load while rising sends the direction low
  a_turn_top: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && i_mode == pwm_timer_pkg::MODE_UPDOWN && o_dir &&
     o_count >= i_load) |=> !o_dir)
    else $error("no turn at load");
  // turn at zero
  // Reaching zero while falling sends the direction high
  a_turn_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && i_mode == pwm_timer_pkg::MODE_UPDOWN && !o_dir &&
     o_count == pwm_timer_pkg::CNT_ZERO) |=> o_dir)
    else $error("no turn at zero");
  // up match split
  // A match while rising must land on the up output
  a_match_up_dir: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && i_run && o_dir && o_count == i_match_a && i_match_a <= i_load) |=>
    o_match_a_up)
    else $error("up match on wrong output");
  // zero single cycle
  // With a nonzero load the count leaves zero, so the pulse drops
  a_zero_single: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (o_zero && i_clk_en && $past(i_clk_en) &&
     $past(i_load) != pwm_timer_pkg::CNT_ZERO) |=> !o_zero)
    else $error("zero pulse too long");
  // stopped gives no events
  // A stopped counter holds its value and raises no zero or load event
  a_run_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (i_clk_en && !i_run) |=> ($stable(o_count) && !o_zero && !o_load))
    else $error("stopped counter moved");
  // Enable low freezes state
  // Count, direction, zero and load pulses hold while the enable is low
  a_freeze_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (!i_clk_en) |=> ($stable(o_count) && $stable(o_dir) && $stable(o_zero) &&
     $stable(o_load)))
    else $error("state moved while frozen");
  // Scenarios
  c_match_a_down: cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    o_match_a_down);
  c_updown_turn: cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    o_dir ##1 !o_dir);
  c_down_wrap: cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    o_zero ##1 o_load);
  c_match_up: cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    o_match_a_up);
  c_match_down: cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    o_match_b_down);
endmodule // pwm_timer
`default_nettype wire

// *** dv/pwm_event_sink.sv ***
// Downstream model tallying the timer event pulses
`timescale 1ns/1ps
`default_nettype none
module pwm_event_sink (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  // Zero, load, a up, a down, b up, b down
  input wire logic [5:0] i_ev,
  // Pulse tallies
  output logic [15:0] o_tally [6]
);
  always_ff @(posedge i_clk or posedge i_rst) begin
    for (int k = 0; k < 6; k++) begin
      if (i_rst) begin
        o_tally[k] <= 16'h0000;
      end else if (i_en) begin
        o_tally[k] <= o_tally[k] + {15'h0000, i_ev[k]};
      end
    end
  end
endmodule // pwm_event_sink
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the PWM counter and compare stage
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst;
  logic en = 1'b0;
  logic run = 1'b0;
  logic mode = 1'b0;
  logic chk = 1'b0;
  logic [15:0] load = 16'h0000, ma = 16'h0000, mb = 16'h0000, count, m_cnt, n_cnt;
  logic [15:0] tally [6], m_tally [6];
  logic dir, m_dir, n_dir;
  logic [5:0] ev, m_ev, n_ev;
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  // Clock at 100 MHz
  always #5 clk = ~clk;
  pwm_timer i_pwm_timer (.I_SYS_CLK(clk), .I_RESET(rst), .i_clk_en(en), .i_run(run),
    .i_mode(mode), .i_load(load), .i_match_a(ma), .i_match_b(mb), .o_count(count),
    .o_dir(dir), .o_zero(ev[5]), .o_load(ev[4]), .o_match_a_up(ev[3]),
    .o_match_a_down(ev[2]), .o_match_b_up(ev[1]), .o_match_b_down(ev[0]));
  pwm_event_sink i_pwm_event_sink (.i_clk(clk), .i_rst(rst), .i_en(en), .i_ev(ev),
    .o_tally(tally));
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      m_cnt <= 16'h0000;
      m_dir <= 1'b0;
      m_ev <= 6'h00;
      for (int k = 0; k < 6; k++) m_tally[k] <= 16'h0000;
    end else if (en) begin
      n_ev = 6'h00;
      n_dir = m_dir;
      n_cnt = m_cnt;
      if (run) begin
        n_ev = {m_cnt == 16'h0000, m_cnt == load, m_cnt == ma && ma <= load && m_dir,
          m_cnt == ma && ma <= load && !m_dir, m_cnt == mb && mb <= load && m_dir,
          m_cnt == mb && mb <= load && !m_dir};
        if (mode) begin
          if (m_cnt == 16'h0000) n_dir = 1'b1;
          else if (m_cnt == load) n_dir = 1'b0;
          n_cnt = n_dir ? m_cnt + 16'h0001 : m_cnt - 16'h0001;
        end else begin
          n_dir = 1'b0;
          n_cnt = (m_cnt == 16'h0000) ? load : m_cnt - 16'h0001;
        end
      end
      for (int k = 0; k < 6; k++) m_tally[k] <= m_tally[k] + {15'h0000, m_ev[k]};
      m_ev <= n_ev;
      m_dir <= n_dir;
      m_cnt <= n_cnt;
    end
  end
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_ev(input logic [5:0] exp, input logic [5:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] events expected %h seen %h", exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Per-cycle comparison and hang guard
  always @(negedge clk) begin
    if (chk) begin
      chk_val("count", m_cnt, count);
      chk_val("dir", {15'h0000, m_dir}, {15'h0000, dir});
      chk_ev(m_ev, ev);
    end
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Reset, configure, run, pause, freeze, run, tally
  task automatic scenario(input logic md, input logic [15:0] ld, a, b);
    @(posedge clk);
    #1 rst = 1'b1;
    mode = md;
    load = ld;
    ma = a;
    mb = b;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (20) @(posedge clk);
    #1 run = 1'b0;
    repeat (3) @(posedge clk);
    #1 run = 1'b1;
    en = 1'b0;
    repeat (3) @(posedge clk);
    #1 en = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    for (int k = 0; k < 6; k++) chk_val("tally", m_tally[k], tally[k]);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    chk = 1'b1;
    en = 1'b1;
    run = 1'b1;
    scenario(pwm_timer_pkg::MODE_DOWN, 16'h0004, 16'h0002, 16'h0005);
    scenario(pwm_timer_pkg::MODE_UPDOWN, 16'h0005, 16'h0000, 16'h0005);
    scenario(pwm_timer_pkg::MODE_UPDOWN, 16'h0003, 16'h0002, 16'h0004);
    scenario(pwm_timer_pkg::MODE_DOWN, 16'h0001, 16'h0001, 16'h0000);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
